//--- crc_ctrl_defines.vh
// crc engine control: register offsets, field positions, reset values
// assumes axi4-lite slave with 32-bit data, byte addresses
`ifndef CRC_CTRL_DEFINES_VH
`define CRC_CTRL_DEFINES_VH

`define CRC_CTRL_OFFSET 8'h00
`define CRC_SEED_OFFSET 8'h04
`define CRC_RESULT_OFFSET 8'h08
`define CRC_POLY_OFFSET 8'h0C
`define CRC_STATUS_OFFSET 8'h10

`define CRC_BYTE_ORDER_SELECT_HI 29
`define CRC_BYTE_ORDER_SELECT_LO 28
`define CRC_WBO_BIT 27
`define CRC_BIT_REFLECT_SELECT_BIT 24
`define CRC_POLY_LENGTH_MINUS_ONE_HI 12
`define CRC_POLY_LENGTH_MINUS_ONE_LO 8
`define CRC_EN_BIT 7
`define CRC_APP_BIT 6
`define CRC_TYP_BIT 5
`define CRC_CH_HI 2
`define CRC_CH_LO 0

`define CRC_CTRL_MASK 32'h3900_1FE7
`define CRC_CTRL_RESET 32'h0000_0000
`define CRC_SEED_RESET 32'h0000_0000
`define CRC_POLY_RESET 32'h0000_0000

`define CRC_ORDER_NONE 2'b00
`define CRC_ORDER_WORD 2'b01
`define CRC_ORDER_HALF 2'b10
`define CRC_ORDER_HSWP 2'b11

`define AXI_RESP_OKAY 2'b00
`define AXI_RESP_SLVERR 2'b10

`endif

//--- crc_fifo.v
// small synchronous fifo with valid/ready on both sides
// assumes one clock, synchronous active-high reset
module crc_fifo #(
    parameter WIDTH = 32,
    parameter DEPTH = 4,
    parameter AW = 2
) (
    // clock and reset
    input wire i_clk,
    input wire i_srst,
    // write side
    input wire i_wr_valid,
    input wire [WIDTH-1:0] i_wr_data,
    output wire o_wr_ready,
    // read side
    output wire o_rd_valid,
    output wire [WIDTH-1:0] o_rd_data,
    input wire i_rd_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wptr_ff;
    reg [AW-1:0] rptr_ff;
    reg [AW:0] count_ff;
    wire push;
    wire pop;

    assign o_wr_ready = (count_ff != DEPTH[AW:0]);
    assign o_rd_valid = (count_ff != {(AW+1){1'b0}});
    assign o_rd_data = mem[rptr_ff];
    assign push = i_wr_valid & o_wr_ready;
    assign pop = o_rd_valid & i_rd_ready;

    always @(posedge i_clk) begin
        if (push) begin
            mem[wptr_ff] <= i_wr_data;
        end
    end

    always @(posedge i_clk) begin
        if (i_srst) begin
            wptr_ff <= {AW{1'b0}};
            rptr_ff <= {AW{1'b0}};
            count_ff <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wptr_ff <= (wptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wptr_ff + 1'b1;
            end
            if (pop) begin
                rptr_ff <= (rptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rptr_ff + 1'b1;
            end
            if (push & ~pop) begin
                count_ff <= count_ff + 1'b1;
            end else if (pop & ~push) begin
                count_ff <= count_ff - 1'b1;
            end
        end
    end
endmodule

//--- dma_crc_control.v
// dma crc engine control: axi4-lite registers, channel tap, lfsr / ip checksum
// assumes one dma channel word stream per source channel, valid/ready handshake
//
// Overview of operation
// (R01) byte order 00 keeps, 01 reverses word
// (R02) 10 swaps half-words, 11 swaps bytes per half
// (R03) write-reorder bit sends reordered data to destination
// (R04) ip checksum reflected when bit-reflect set
// (R05) lfsr crc reflected when bit-reflect set
// (R06) type bit 1 ip checksum, 0 lfsr
// (R07) poly length field is length minus one
// (R08) ip checksum ignores poly length field
// (R09) enable routes selected channel through engine
// (R10) append mode refused while write-reorder set
// (R11) unimplemented bits read zero, fields reset zero
// (R12) channel select picks the tapped channel
// (R13) append mode drops data, delivers checksum only
`include "crc_ctrl_defines.vh"

module dma_crc_control #(
    parameter NUM_CH = 8,
    parameter FIFO_DEPTH = 4
) (
    // clock and reset
    input wire i_clk,
    input wire i_srst,
    // axi4-lite write address
    input wire i_awvalid,
    output wire o_awready,
    input wire [7:0] i_awaddr,
    // axi4-lite write data
    input wire i_wvalid,
    output wire o_wready,
    input wire [31:0] i_wdata,
    input wire [3:0] i_wstrb,
    // axi4-lite write response
    output wire o_bvalid,
    input wire i_bready,
    output wire [1:0] o_bresp,
    // axi4-lite read address
    input wire i_arvalid,
    output wire o_arready,
    input wire [7:0] i_araddr,
    // axi4-lite read data
    output wire o_rvalid,
    input wire i_rready,
    output wire [31:0] o_rdata,
    output wire [1:0] o_rresp,
    // dma source stream, one word per beat
    input wire i_src_valid,
    input wire [2:0] i_src_channel,
    input wire [31:0] i_src_data,
    input wire i_src_last,
    output wire o_src_ready,
    // dma destination stream
    output wire o_dst_valid,
    output wire [31:0] o_dst_data,
    input wire i_dst_ready,
    // engine state
    output wire o_engine_busy
);
    // control register fields
    reg [1:0] byte_order_select_ff;
    reg write_reorder_enable_ff;
    reg bit_reflect_select_ff;
    reg [4:0] poly_length_minus_one_ff;
    reg engine_enable_ff;
    reg append_mode_ff;
    reg checksum_type_select_ff;
    reg [2:0] source_channel_select_ff;
    reg [31:0] seed_ff;
    reg [31:0] poly_ff;
    reg [31:0] crc_ff;
    reg [31:0] nxt_crc;
    reg seed_load_ff;

    // bus state
    reg aw_got_ff;
    reg w_got_ff;
    reg [7:0] awaddr_ff;
    reg [31:0] wdata_ff;
    reg [3:0] wstrb_ff;
    reg bvalid_ff;
    reg [1:0] bresp_ff;
    reg rvalid_ff;
    reg [31:0] rdata_ff;
    reg [1:0] rresp_ff;

    // stream state: one-hot
    localparam ST_RUN = 2'b01;
    localparam ST_RES = 2'b10;
    reg [1:0] state_ff;

    wire [31:0] ctrl_word;
    wire [31:0] merged;
    wire wr_fire;
    wire [31:0] ordered;
    wire tap;
    wire fifo_wr_valid;
    wire fifo_wr_ready;
    wire [31:0] fifo_wr_data;
    wire [31:0] crc_mask;

    assign ctrl_word = {2'b00, byte_order_select_ff, write_reorder_enable_ff, 2'b00,
                        bit_reflect_select_ff, 11'h000, poly_length_minus_one_ff,
                        engine_enable_ff, append_mode_ff, checksum_type_select_ff, 2'b00,
                        source_channel_select_ff}; // R11

    // byte reordering
    function [31:0] reorder;
        input [31:0] d;
        input [1:0] sel;
        begin
            case (sel)
                `CRC_ORDER_WORD: reorder = {d[7:0], d[15:8], d[23:16], d[31:24]}; // R01
                `CRC_ORDER_HALF: reorder = {d[15:0], d[31:16]}; // R02
                `CRC_ORDER_HSWP: reorder = {d[23:16], d[31:24], d[7:0], d[15:8]}; // R02
                default: reorder = d; // R01
            endcase
        end
    endfunction

    function [31:0] bitrev32;
        input [31:0] d;
        integer k;
        begin
            for (k = 0; k < 32; k = k + 1) begin
                bitrev32[k] = d[31-k];
            end
        end
    endfunction

    function [15:0] bitrev16;
        input [15:0] d;
        integer k;
        begin
            for (k = 0; k < 16; k = k + 1) begin
                bitrev16[k] = d[15-k];
            end
        end
    endfunction

    // axi write path: address and data taken in either order
    assign o_awready = ~aw_got_ff & ~bvalid_ff;
    assign o_wready = ~w_got_ff & ~bvalid_ff;
    assign o_bvalid = bvalid_ff;
    assign o_bresp = bresp_ff;
    assign wr_fire = aw_got_ff & w_got_ff & ~bvalid_ff;

    genvar gb;
    generate
        for (gb = 0; gb < 4; gb = gb + 1) begin : g_lane
            assign merged[gb*8+7:gb*8] = wstrb_ff[gb] ? wdata_ff[gb*8+7:gb*8] : ctrl_word[gb*8+7:gb*8];
        end
    endgenerate

    always @(posedge i_clk) begin
        if (i_srst) begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            awaddr_ff <= 8'h00;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
            bvalid_ff <= 1'b0;
            bresp_ff <= `AXI_RESP_OKAY;
            byte_order_select_ff <= 2'b00; // R11
            write_reorder_enable_ff <= 1'b0;
            bit_reflect_select_ff <= 1'b0;
            poly_length_minus_one_ff <= 5'h00;
            engine_enable_ff <= 1'b0;
            append_mode_ff <= 1'b0;
            checksum_type_select_ff <= 1'b0;
            source_channel_select_ff <= 3'b000;
            seed_ff <= `CRC_SEED_RESET;
            poly_ff <= `CRC_POLY_RESET;
            seed_load_ff <= 1'b0;
        end else begin
            seed_load_ff <= 1'b0;
            if (i_awvalid & o_awready) begin
                aw_got_ff <= 1'b1;
                awaddr_ff <= i_awaddr;
            end
            if (i_wvalid & o_wready) begin
                w_got_ff <= 1'b1;
                wdata_ff <= i_wdata;
                wstrb_ff <= i_wstrb;
            end
            if (bvalid_ff & i_bready) begin
                bvalid_ff <= 1'b0;
            end
            if (wr_fire) begin
                aw_got_ff <= 1'b0;
                w_got_ff <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff <= `AXI_RESP_OKAY;
                case ({awaddr_ff[7:2], 2'b00})
                    `CRC_CTRL_OFFSET: begin
                        byte_order_select_ff <= merged[`CRC_BYTE_ORDER_SELECT_HI:`CRC_BYTE_ORDER_SELECT_LO];
                        write_reorder_enable_ff <= merged[`CRC_WBO_BIT];
                        bit_reflect_select_ff <= merged[`CRC_BIT_REFLECT_SELECT_BIT];
                        poly_length_minus_one_ff <= merged[`CRC_POLY_LENGTH_MINUS_ONE_HI:`CRC_POLY_LENGTH_MINUS_ONE_LO];
                        engine_enable_ff <= merged[`CRC_EN_BIT];
                        // append cannot be set with write-reorder on
                        append_mode_ff <= merged[`CRC_APP_BIT] & ~merged[`CRC_WBO_BIT]; // R10
                        checksum_type_select_ff <= merged[`CRC_TYP_BIT];
                        source_channel_select_ff <= merged[`CRC_CH_HI:`CRC_CH_LO];
                    end
                    `CRC_SEED_OFFSET: begin
                        seed_ff <= i_wdata_sel(wdata_ff, wstrb_ff, seed_ff);
                        seed_load_ff <= 1'b1;
                    end
                    `CRC_POLY_OFFSET: begin
                        poly_ff <= i_wdata_sel(wdata_ff, wstrb_ff, poly_ff);
                    end
                    `CRC_RESULT_OFFSET, `CRC_STATUS_OFFSET: begin
                        bresp_ff <= `AXI_RESP_OKAY;
                    end
                    default: begin
                        bresp_ff <= `AXI_RESP_SLVERR;
                    end
                endcase
            end
        end
    end

    function [31:0] i_wdata_sel;
        input [31:0] d;
        input [3:0] s;
        input [31:0] old;
        integer k;
        begin
            for (k = 0; k < 32; k = k + 1) begin
                i_wdata_sel[k] = s[k/8] ? d[k] : old[k];
            end
        end
    endfunction

    // axi read path, answer one cycle after address
    assign o_arready = ~rvalid_ff;
    assign o_rvalid = rvalid_ff;
    assign o_rdata = rdata_ff;
    assign o_rresp = rresp_ff;

    always @(posedge i_clk) begin
        if (i_srst) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= `AXI_RESP_OKAY;
        end else if (rvalid_ff) begin
            if (i_rready) begin
                rvalid_ff <= 1'b0;
            end
        end else if (i_arvalid) begin
            rvalid_ff <= 1'b1;
            rresp_ff <= `AXI_RESP_OKAY;
            case ({i_araddr[7:2], 2'b00})
                `CRC_CTRL_OFFSET: rdata_ff <= ctrl_word & `CRC_CTRL_MASK; // R11
                `CRC_SEED_OFFSET: rdata_ff <= seed_ff;
                `CRC_RESULT_OFFSET: rdata_ff <= crc_ff & crc_mask;
                `CRC_POLY_OFFSET: rdata_ff <= poly_ff;
                `CRC_STATUS_OFFSET: rdata_ff <= {31'h0000_0000, state_ff[1]};
                default: begin
                    rdata_ff <= 32'h0000_0000;
                    rresp_ff <= `AXI_RESP_SLVERR;
                end
            endcase
        end
    end

    // channel tap and data path
    assign tap = engine_enable_ff & (i_src_channel == source_channel_select_ff); // R09 R12
    assign ordered = reorder(i_src_data, byte_order_select_ff);
    assign fifo_wr_valid = (state_ff == ST_RES) | (i_src_valid & ~(tap & append_mode_ff)); // R13
    assign fifo_wr_data = (state_ff == ST_RES) ? (crc_ff & crc_mask) : // R13
                          (tap & write_reorder_enable_ff) ? ordered : i_src_data; // R03
    // stall source while the result word is queued
    assign o_src_ready = (state_ff == ST_RUN) & (fifo_wr_ready | (tap & append_mode_ff));
    assign o_engine_busy = state_ff[1];

    // mask of poly length bits; ip checksum is never masked, the length field is dead there
    assign crc_mask = (checksum_type_select_ff | (poly_length_minus_one_ff == 5'h1F)) ? 32'hFFFF_FFFF : // R08
                      ((32'h0000_0002 << poly_length_minus_one_ff) - 32'h0000_0001); // R07

    // checksum computation
    always @* begin : p_crc
        reg [31:0] d;
        reg [31:0] c;
        reg fb;
        reg [16:0] s;
        integer k;
        d = ordered;
        c = crc_ff;
        fb = 1'b0;
        s = 17'h0_0000;
        k = 0;
        if (checksum_type_select_ff) begin
            // ones-complement sum of two half-words; length field unused
            if (bit_reflect_select_ff) begin // R04
                d = {bitrev16(d[31:16]), bitrev16(d[15:0])};
            end
            s = {1'b0, c[15:0]} + {1'b0, d[31:16]};
            s = {1'b0, s[15:0]} + {16'h0000, s[16]};
            s = {1'b0, s[15:0]} + {1'b0, d[15:0]};
            s = {1'b0, s[15:0]} + {16'h0000, s[16]};
            nxt_crc = {16'h0000, s[15:0]}; // R06 R08
        end else begin
            if (bit_reflect_select_ff) begin // R05
                d = bitrev32(d);
            end
            for (k = 31; k >= 0; k = k - 1) begin
                fb = c[poly_length_minus_one_ff] ^ d[k]; // R07
                c = ((c << 1) ^ (fb ? poly_ff : 32'h0000_0000)) & crc_mask;
            end
            nxt_crc = c; // R06
        end
    end

    always @(posedge i_clk) begin
        if (i_srst) begin
            crc_ff <= 32'h0000_0000;
            state_ff <= ST_RUN;
        end else begin
            case (state_ff)
                ST_RUN: begin
                    if (seed_load_ff) begin
                        crc_ff <= seed_ff;
                    end else if (i_src_valid & o_src_ready & tap) begin
                        crc_ff <= nxt_crc;
                        if (i_src_last & append_mode_ff) begin
                            state_ff <= ST_RES; // R13
                        end
                    end
                end
                ST_RES: begin
                    if (fifo_wr_ready) begin
                        state_ff <= ST_RUN;
                    end
                end
                default: state_ff <= ST_RUN;
            endcase
        end
    end

    crc_fifo #(
        .WIDTH(32),
        .DEPTH(FIFO_DEPTH),
        .AW(2)
    ) u_fifo (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_wr_valid(fifo_wr_valid),
        .i_wr_data(fifo_wr_data),
        .o_wr_ready(fifo_wr_ready),
        .o_rd_valid(o_dst_valid),
        .o_rd_data(o_dst_data),
        .i_rd_ready(i_dst_ready)
    );
endmodule

//--- dma_crc_control_asserts.sv
// port-level checker for the dma crc control block
// assumes one clock domain, synchronous active-high reset, bound by the bind below
`include "crc_ctrl_defines.vh"
module dma_crc_control_checker #(
    parameter NUM_CH = 8,
    parameter FIFO_DEPTH = 4
) (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_awvalid,
    input wire logic o_awready,
    input wire logic i_wvalid,
    input wire logic o_wready,
    input wire logic o_bvalid,
    input wire logic i_bready,
    input wire logic [1:0] o_bresp,
    input wire logic i_arvalid,
    input wire logic o_arready,
    input wire logic [7:0] i_araddr,
    input wire logic o_rvalid,
    input wire logic i_rready,
    input wire logic [31:0] o_rdata,
    input wire logic [1:0] o_rresp,
    input wire logic o_src_ready,
    input wire logic o_dst_valid,
    input wire logic [31:0] o_dst_data,
    input wire logic i_dst_ready,
    input wire logic o_engine_busy
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);
    property p_b_hold; o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp); endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
    property p_r_hold; o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata); endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
    property p_dst_hold; o_dst_valid && !i_dst_ready |=> o_dst_valid && $stable(o_dst_data); endproperty
    a_dst_hold: assert property (p_dst_hold) else $error("destination word dropped early");
    property p_aw_block; o_bvalid |-> !o_awready && !o_wready; endproperty
    a_aw_block: assert property (p_aw_block) else $error("write accepted during response");
    property p_ar_block; o_rvalid |-> !o_arready; endproperty
    a_ar_block: assert property (p_ar_block) else $error("read accepted during response");
    property p_r_answer; i_arvalid && o_arready |=> o_rvalid; endproperty
    a_r_answer: assert property (p_r_answer) else $error("read answer late");
    property p_b_answer; i_awvalid && o_awready && i_wvalid && o_wready |-> ##2 o_bvalid; endproperty
    a_b_answer: assert property (p_b_answer) else $error("write answer late");
    property p_unmapped;
        i_arvalid && o_arready && i_araddr > 8'h13 |=> o_rresp == `AXI_RESP_SLVERR && o_rdata == 32'h0000_0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
    property p_ctrl_mask;
        i_arvalid && o_arready && i_araddr == `CRC_CTRL_OFFSET |=> (o_rdata & ~`CRC_CTRL_MASK) == 32'h0000_0000;
    endproperty
    a_ctrl_mask: assert property (p_ctrl_mask) else $error("unused control bit reads one");
    property p_busy_stall; o_engine_busy |-> !o_src_ready; endproperty
    a_busy_stall: assert property (p_busy_stall) else $error("source taken while result pending");
endmodule

bind dma_crc_control dma_crc_control_checker #(.NUM_CH(NUM_CH), .FIFO_DEPTH(FIFO_DEPTH)) chk (.i_clk(i_clk),
    .i_srst(i_srst), .i_awvalid(i_awvalid), .o_awready(o_awready), .i_wvalid(i_wvalid), .o_wready(o_wready),
    .o_bvalid(o_bvalid), .i_bready(i_bready), .o_bresp(o_bresp), .i_arvalid(i_arvalid), .o_arready(o_arready),
    .i_araddr(i_araddr), .o_rvalid(o_rvalid), .i_rready(i_rready), .o_rdata(o_rdata), .o_rresp(o_rresp),
    .o_src_ready(o_src_ready), .o_dst_valid(o_dst_valid), .o_dst_data(o_dst_data), .i_dst_ready(i_dst_ready),
    .o_engine_busy(o_engine_busy));

//--- dma_sink_model.sv
// destination side of the dma channel: takes words with a selectable stall
// assumes valid/ready handshake; mode 0 always ready, 1 every fourth cycle, 2 never
module dma_sink_model (
    // clock
    input wire logic i_clk,
    // stream from the block
    input wire logic i_valid,
    input wire logic [31:0] i_data,
    input wire logic [1:0] i_mode,
    output logic o_ready,
    // words seen, one cycle after the handshake
    output logic o_seen = 1'b0,
    output logic [31:0] o_word
);
    logic [1:0] cnt_ff = 2'd0;
    assign o_ready = (i_mode == 2'd0) || (i_mode == 2'd1 && cnt_ff == 2'd3);
    always @(posedge i_clk) begin
        cnt_ff <= cnt_ff + 2'd1;
        o_seen <= i_valid && o_ready;
        o_word <= i_data;
    end
endmodule

//--- testbench.sv
// self-checking bench: register bus, channel tap, reorder, append checksum, fifo fill
// assumes the design and checker files are compiled first
`include "crc_ctrl_defines.vh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk = 0, i_srst = 1;
    logic i_awvalid = 0, i_wvalid = 0, i_bready = 0, i_arvalid = 0, i_rready = 0;
    logic [7:0] i_awaddr = 0, i_araddr = 0;
    logic [31:0] i_wdata = 0, i_src_data = 0;
    logic [2:0] i_src_channel = 0;
    logic i_src_valid = 0, i_src_last = 0;
    logic [1:0] sink_mode = 2'd1;
    wire o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_src_ready, o_dst_valid, o_engine_busy;
    wire i_dst_ready, seen;
    wire [1:0] o_bresp, o_rresp;
    wire [31:0] o_rdata, o_dst_data, word;
    logic [31:0] got_q[$];
    logic [1:0] r;
    int fails = 0, compares = 0, k;
    // one row per ordinary pass-through case: control value, channel, expected destination word
    logic [31:0] row_ctrl[7] = '{32'h0800_0082, 32'h1800_0082, 32'h2800_0082, 32'h3800_0082,
        32'h1000_0082, 32'h1800_0002, 32'h1800_0082};
    logic [2:0] row_ch[7] = '{3'd2, 3'd2, 3'd2, 3'd2, 3'd2, 3'd2, 3'd5};
    logic [31:0] row_exp[7] = '{32'h1122_3344, 32'h4433_2211, 32'h3344_1122, 32'h2211_4433,
        32'h1122_3344, 32'h1122_3344, 32'h1122_3344};

    dma_crc_control dut (.i_clk(i_clk), .i_srst(i_srst), .i_awvalid(i_awvalid), .o_awready(o_awready),
        .i_awaddr(i_awaddr), .i_wvalid(i_wvalid), .o_wready(o_wready), .i_wdata(i_wdata), .i_wstrb(4'hf),
        .o_bvalid(o_bvalid), .i_bready(i_bready), .o_bresp(o_bresp), .i_arvalid(i_arvalid),
        .o_arready(o_arready), .i_araddr(i_araddr), .o_rvalid(o_rvalid), .i_rready(i_rready),
        .o_rdata(o_rdata), .o_rresp(o_rresp), .i_src_valid(i_src_valid), .i_src_channel(i_src_channel),
        .i_src_data(i_src_data), .i_src_last(i_src_last), .o_src_ready(o_src_ready),
        .o_dst_valid(o_dst_valid), .o_dst_data(o_dst_data), .i_dst_ready(i_dst_ready),
        .o_engine_busy(o_engine_busy));
    dma_sink_model sink (.i_clk(i_clk), .i_valid(o_dst_valid), .i_data(o_dst_data), .i_mode(sink_mode),
        .o_ready(i_dst_ready), .o_seen(seen), .o_word(word));

    initial begin
        forever #20 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        if (seen === 1'b1) got_q.push_back(word);
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
        logic ta, tw;
        @(posedge i_clk);
        i_awvalid <= 1; i_wvalid <= 1; i_awaddr <= a; i_wdata <= d; i_bready <= 1;
        ta = 0; tw = 0;
        while (!(ta && tw)) begin
            @(negedge i_clk);
            if (o_awready === 1'b1 && !ta) ta = 1;
            if (o_wready === 1'b1 && !tw) tw = 1;
            @(posedge i_clk);
            if (ta) i_awvalid <= 0;
            if (tw) i_wvalid <= 0;
        end
        do @(negedge i_clk); while (o_bvalid !== 1'b1);
        resp = o_bresp;
        @(posedge i_clk) i_bready <= 0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] exp_r);
        @(posedge i_clk);
        i_arvalid <= 1; i_araddr <= a; i_rready <= 1;
        do @(negedge i_clk); while (o_arready !== 1'b1);
        @(posedge i_clk) i_arvalid <= 0;
        do @(negedge i_clk); while (o_rvalid !== 1'b1);
        chk(o_rdata, exp);
        chk(o_rresp, exp_r);
        @(posedge i_clk) i_rready <= 0;
    endtask
    task send(input logic [2:0] ch, input logic [31:0] d, input logic last);
        @(posedge i_clk);
        i_src_valid <= 1; i_src_channel <= ch; i_src_data <= d; i_src_last <= last;
        do @(negedge i_clk); while (o_src_ready !== 1'b1);
        @(posedge i_clk) i_src_valid <= 0;
    endtask
    task wait_q(input int n);
        for (k = 0; k < 40 && got_q.size() < n; k++) @(posedge i_clk);
    endtask
    task tally_and_finish;
        $display("comparisons %0d mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    initial begin
        #(40 * 4000);
        fails++;
        tally_and_finish;
    end
    initial begin
        repeat (5) @(posedge i_clk);
        i_srst <= 0;
        rd(`CRC_CTRL_OFFSET, 32'h0000_0000, `AXI_RESP_OKAY);
        wr(`CRC_CTRL_OFFSET, 32'hFFFF_FFFF, r);
        rd(`CRC_CTRL_OFFSET, 32'h3900_1FA7, `AXI_RESP_OKAY);
        wr(`CRC_CTRL_OFFSET, 32'h0000_0040, r);
        rd(`CRC_CTRL_OFFSET, 32'h0000_0040, `AXI_RESP_OKAY);
        wr(8'h40, 32'h1234_5678, r);
        chk(r, `AXI_RESP_SLVERR);
        rd(8'h40, 32'h0000_0000, `AXI_RESP_SLVERR);
        @(posedge i_clk) i_srst <= 1;
        @(posedge i_clk) i_srst <= 0;
        rd(`CRC_CTRL_OFFSET, 32'h0000_0000, `AXI_RESP_OKAY);
        for (int i = 0; i < 7; i++) begin
            wr(`CRC_CTRL_OFFSET, row_ctrl[i], r);
            got_q.delete();
            send(row_ch[i], 32'h1122_3344, 1'b0);
            wait_q(1);
            chk(got_q.size() > 0 ? got_q[0] : 32'h0, row_exp[i]);
        end
        // ip checksum, append, short poly field which must not matter
        sink_mode <= 2'd0;
        wr(`CRC_SEED_OFFSET, 32'h0000_0000, r);
        wr(`CRC_CTRL_OFFSET, 32'h0000_03E3, r);
        got_q.delete();
        send(3'd3, 32'h1122_3344, 1'b0);
        send(3'd3, 32'h0000_0001, 1'b1);
        wait_q(1);
        repeat (8) @(posedge i_clk);
        chk(got_q.size(), 32'd1);
        chk(got_q.size() > 0 ? got_q[0] : 32'h0, 32'h0000_4467);
        rd(`CRC_RESULT_OFFSET, 32'h0000_4467, `AXI_RESP_OKAY);
        // lfsr, 8-bit poly, reflected input: one set bit lands as the poly itself
        wr(`CRC_POLY_OFFSET, 32'h0000_0007, r);
        wr(`CRC_CTRL_OFFSET, 32'h0100_0781, r);
        wr(`CRC_SEED_OFFSET, 32'h0000_0000, r);
        send(3'd1, 32'h8000_0000, 1'b0);
        rd(`CRC_RESULT_OFFSET, 32'h0000_0007, `AXI_RESP_OKAY);
        // fill the fifo against a stalled sink, then drain it
        wr(`CRC_CTRL_OFFSET, 32'h0000_0000, r);
        sink_mode <= 2'd2;
        got_q.delete();
        for (int i = 0; i < 4; i++) send(3'd0, 32'h0000_00A0 + i, 1'b0);
        @(negedge i_clk);
        chk(o_src_ready, 1'b0);
        @(posedge i_clk) sink_mode <= 2'd0;
        wait_q(4);
        for (int i = 0; i < 4; i++) chk(got_q.size() > i ? got_q[i] : 32'h0, 32'h0000_00A0 + i);
        tally_and_finish;
    end
endmodule
